// >>> core/elst_map.svh
// Purpose: Offsets, field masks and reset values of the line trigger block
// Assumes: Byte addresses on a 32-bit classic Wishbone slave
// Notes:   Definitions only
`ifndef ELST_MAP_SVH
`define ELST_MAP_SVH

// ==========================================================
// Register offsets
`define ELST_OFF_IMASK   8'h00
`define ELST_OFF_EMASK   8'h04
`define ELST_OFF_RISE    8'h08
`define ELST_OFF_FALL    8'h0C
`define ELST_OFF_SWTRIG  8'h10
`define ELST_OFF_PEND    8'h14

// ==========================================================
// Fields and reset values
`define ELST_LINE_MASK   20'hBFFFF
`define ELST_LINES       20
`define ELST_RST_REG     20'h00000
`define ELST_RST_WORD    32'h00000000

`endif

// >>> core/elst_pkg.sv
// Purpose: Types shared by the line trigger block
// Assumes: Classic Wishbone, 32-bit data, 8-bit byte address
// Notes:   Request signals travel as one packed struct
`default_nettype none

package elst_pkg;

   typedef logic [19:0] elst_lines_t;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } elst_wb_req_s;

endpackage

`default_nettype wire

// >>> core/elst_top.sv
// Purpose: External line controller with software trigger, pending flags and masks
// Assumes: One clock ref_clk_i at 50 MHz, asynchronous active-low reset
// Notes:   Lines 0..17 and 19 exist; bit 18 and bits 31:20 are reserved
//
// How it works
// [RULE_01] Writing one to request bit raises line request
// [RULE_02] Writing zero changes neither request nor pending
// [RULE_03] Request bit clears only via pending write-one
// [RULE_04] Request rising from zero sets pending flag
// [RULE_05] Interrupt and event gated by their masks
// [RULE_06] Edge sets pending; write-one or polarity clears
// [RULE_07] Reserved bits read zero, writes ignored
`include "elst_map.svh"
`default_nettype none

module elst_top
   import elst_pkg::*;
#(
   parameter int NUM_LINES = `ELST_LINES
)
(
   input  wire logic         ref_clk_i,
   input  wire logic         resetn_i,
   input  wire elst_wb_req_s wb_req_i,
   output logic [31:0]       wb_dat_o,
   output logic              wb_ack_o,
   input  wire logic [19:0]  line_i,
   output logic              irq_o,
   output logic              evt_o
);

   // ==========================================================
   // Elaboration check
   if (NUM_LINES != `ELST_LINES)
   begin : g_bad_lines
      $error("elst_top supports exactly 20 line positions");
   end

   localparam elst_lines_t VALID = `ELST_LINE_MASK;

   // ==========================================================
   // Declarations
   elst_lines_t imask;
   elst_lines_t emask;
   elst_lines_t rise_en;
   elst_lines_t fall_en;
   elst_lines_t swtrig;
   elst_lines_t pend;
   elst_lines_t sync_a;
   elst_lines_t sync_b;
   elst_lines_t line_q;
   elst_lines_t edge_hit;
   elst_lines_t wen;
   elst_lines_t wdat;
   elst_lines_t sw_wr;
   elst_lines_t sw_set;
   elst_lines_t pend_clr;
   elst_lines_t pol_clr;
   elst_lines_t pol_only;
   elst_lines_t next_rise;
   elst_lines_t next_fall;
   elst_lines_t next_pend;
   logic [31:0] byte_mask;
   logic [31:0] rdata;
   logic        req;
   logic        wr;

   // ==========================================================
   // Bus decode
   assign req       = wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
   assign wr        = req & wb_req_i.we;
   assign byte_mask = {{8{wb_req_i.sel[3]}}, {8{wb_req_i.sel[2]}},
                       {8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};
   // Reserved positions never see a write
   assign wen       = byte_mask[19:0] & VALID;  // RULE_07
   assign wdat      = wb_req_i.dat[19:0] & wen;

   assign sw_wr    = (wr && wb_req_i.adr == `ELST_OFF_SWTRIG) ? wdat : `ELST_RST_REG;  // RULE_01
   // Only a zero-to-one change of the request bit makes a new pending edge
   assign sw_set   = sw_wr & ~swtrig;  // RULE_04
   assign pend_clr = (wr && wb_req_i.adr == `ELST_OFF_PEND) ? wdat : `ELST_RST_REG;

   assign next_rise = (wr && wb_req_i.adr == `ELST_OFF_RISE) ?
                      ((rise_en & ~wen) | wdat) : rise_en;
   assign next_fall = (wr && wb_req_i.adr == `ELST_OFF_FALL) ?
                      ((fall_en & ~wen) | wdat) : fall_en;
   assign pol_clr   = (rise_en ^ next_rise) | (fall_en ^ next_fall);  // RULE_06
   assign pol_only  = pol_clr & ~edge_hit & ~sw_set;

   // Set wins over clear so no edge is lost
   assign next_pend = ((pend & ~(pend_clr | pol_clr)) | edge_hit | sw_set) & VALID;  // RULE_06

   // ==========================================================
   // Line inputs: two-stage sync, then edge detect
   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         sync_a <= `ELST_RST_REG;
         sync_b <= `ELST_RST_REG;
         line_q <= `ELST_RST_REG;
      end
      else
      begin
         sync_a <= line_i;
         sync_b <= sync_a;
         line_q <= sync_b;
      end
   end

   for (genvar i = 0; i < NUM_LINES; i++)
   begin : g_edge
      assign edge_hit[i] = VALID[i] & ((rise_en[i] & sync_b[i] & ~line_q[i]) |
                                       (fall_en[i] & ~sync_b[i] & line_q[i]));  // RULE_06
   end

   // ==========================================================
   // Configuration registers
   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         imask   <= `ELST_RST_REG;
         emask   <= `ELST_RST_REG;
         rise_en <= `ELST_RST_REG;
         fall_en <= `ELST_RST_REG;
      end
      else
      begin
         if (wr && wb_req_i.adr == `ELST_OFF_IMASK)
         begin
            imask <= (imask & ~wen) | wdat;
         end
         if (wr && wb_req_i.adr == `ELST_OFF_EMASK)
         begin
            emask <= (emask & ~wen) | wdat;
         end
         rise_en <= next_rise;
         fall_en <= next_fall;
      end
   end

   // ==========================================================
   // Software request and pending flags
   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         swtrig <= `ELST_RST_REG;
         pend   <= `ELST_RST_REG;
      end
      else
      begin
         // Zero bits in the write leave the request alone
         swtrig <= (swtrig & ~pend_clr) | sw_wr;  // RULE_02 RULE_03
         pend   <= next_pend;
      end
   end

   // ==========================================================
   // Interrupt level and event pulse
   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         irq_o <= 1'b0;
         evt_o <= 1'b0;
      end
      else
      begin
         irq_o <= |(pend & imask);                 // RULE_05
         evt_o <= |((edge_hit | sw_set) & emask);  // RULE_05
      end
   end

   // ==========================================================
   // Bus answer: one wait state, unmapped reads give zero
   always_comb
   begin
      rdata = `ELST_RST_WORD;
      case (wb_req_i.adr)
         `ELST_OFF_IMASK:  rdata = {12'h000, imask};
         `ELST_OFF_EMASK:  rdata = {12'h000, emask};
         `ELST_OFF_RISE:   rdata = {12'h000, rise_en};
         `ELST_OFF_FALL:   rdata = {12'h000, fall_en};
         `ELST_OFF_SWTRIG: rdata = {12'h000, swtrig};
         `ELST_OFF_PEND:   rdata = {12'h000, pend};
         default:          rdata = `ELST_RST_WORD;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= `ELST_RST_WORD;
      end
      else
      begin
         wb_ack_o <= req;
         if (req)
         begin
            wb_dat_o <= rdata;  // RULE_07
         end
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);

   a_sw_write_one: assert property ((sw_wr != 20'h00000) |=>  // RULE_01
      ((swtrig & $past(sw_wr)) == $past(sw_wr)))
      else $error("request bit not set by write of one");
   a_zero_write_keeps: assert property ((sw_wr == 20'h00000 && pend_clr == 20'h00000) |=>  // RULE_02
      (swtrig == $past(swtrig)))
      else $error("request bits changed without cause");
   a_sw_clear_path: assert property ((pend_clr != 20'h00000) |=>  // RULE_03
      ((swtrig & $past(pend_clr)) == 20'h00000))
      else $error("request bit survived pending clear");
   a_sw_sets_pend: assert property ((sw_set != 20'h00000) |=>  // RULE_04
      ((pend & $past(sw_set)) == $past(sw_set)))
      else $error("software request did not set pending");
   a_irq_gated: assert property ((pend & imask) == 20'h00000 |=> !irq_o)  // RULE_05
      else $error("interrupt raised with all sources masked");
   a_evt_pulse: assert property (((sw_set & emask) != 20'h00000) |=> evt_o ##1  // RULE_05
      (evt_o == $past(|((edge_hit | sw_set) & emask))))
      else $error("event pulse missing for open line");
   a_pol_clears: assert property ((pol_only != 20'h00000) |=>  // RULE_06
      ((pend & $past(pol_only)) == 20'h00000))
      else $error("polarity change did not clear pending");
   a_rsvd_zero: assert property (wb_ack_o |-> (wb_dat_o[31:20] == 12'h000 &&  // RULE_07
      wb_dat_o[18] == 1'b0))
      else $error("reserved bit read as one");

   c_sw_trigger: cover property (sw_set != 20'h00000 ##1 irq_o);
   c_pend_clear: cover property (pend_clr != 20'h00000 ##1 swtrig == 20'h00000);
   c_line_edge:  cover property (edge_hit != 20'h00000 ##1 evt_o);

endmodule

`default_nettype wire

// >>> testbench/tb_ext_line_soft_trigger.sv
// Purpose: Self-checking bench for the software line trigger block
// Assumes: Registered ack one cycle after a request is taken
// Notes:   Events are counted by a monitor and compared after each write of ones to the request register and after the line edge
`default_nettype none

module tb_ext_line_soft_trigger
   import elst_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // Signals and checks
   `define CHK(g, e) \
      begin \
         n_checks++; \
         if ((g) !== (e)) \
         begin \
            miscompares++; \
            $display("unexpected at %0t: got %h exp %h", $time, g, e); \
         end \
      end

   logic         ref_clk_i;
   logic         resetn_i;
   elst_wb_req_s req;
   logic [31:0]  dat;
   logic         ack;
   logic [19:0]  line;
   logic         irq;
   logic         evt;
   int           miscompares = 0;
   int           n_checks = 0;
   int           n_evt = 0;

   elst_top u_dut (
      .ref_clk_i (ref_clk_i),
      .resetn_i  (resetn_i),
      .wb_req_i  (req),
      .wb_dat_o  (dat),
      .wb_ack_o  (ack),
      .line_i    (line),
      .irq_o     (irq),
      .evt_o     (evt)
   );

   initial
   begin
      ref_clk_i = 1'b0;
      forever #10 ref_clk_i = ~ref_clk_i;
   end

   always @(posedge ref_clk_i)
   begin
      if (evt === 1'b1)
         n_evt <= n_evt + 1;
   end

   // ==========================================================
   // Bus tasks
   task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge ref_clk_i);
      req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
      // Waits for ack however long it takes; only the watchdog ends a hang
      do
         @(posedge ref_clk_i);
      while (ack !== 1'b1);
      q = dat;
      req.cyc <= 1'b0;
      req.stb <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      xfer(1'b0, a, 32'h00000000, q);
      `CHK(q, e)
   endtask

   task automatic conclude();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Bounds a hang well beyond the fewer than 100 cycles of the sequence
   initial
   begin
      repeat (5000) @(posedge ref_clk_i);
      miscompares++;
      conclude();
   end

   // ==========================================================
   // Sequence
   initial
   begin
      resetn_i = 1'b0;
      req = '0;
      line = 20'h00000;
      repeat (2) @(posedge ref_clk_i);
      resetn_i <= 1'b1;
      rd(8'h10, 32'h00000000);
      rd(8'h14, 32'h00000000);
      wr(8'h04, 32'h00080003);
      wr(8'h00, 32'h00000001);
      wr(8'h10, 32'h00000001);
      rd(8'h10, 32'h00000001);
      rd(8'h14, 32'h00000001);
      `CHK(irq, 1'b1)
      `CHK(n_evt, 1)
      wr(8'h10, 32'h00000000);
      rd(8'h10, 32'h00000001);
      rd(8'h14, 32'h00000001);
      wr(8'h10, 32'h00000001);
      // Let the monitor count a stray pulse before looking
      @(posedge ref_clk_i);
      `CHK(n_evt, 1)
      wr(8'h10, 32'hFFFFFFFF);
      rd(8'h10, 32'h000BFFFF);
      rd(8'h14, 32'h000BFFFF);
      `CHK(n_evt, 2)
      wr(8'h14, 32'h00000001);
      rd(8'h10, 32'h000BFFFE);
      `CHK(irq, 1'b0)
      wr(8'h14, 32'hFFFFFFFF);
      rd(8'h10, 32'h00000000);
      rd(8'h14, 32'h00000000);
      wr(8'h10, 32'h00080000);
      rd(8'h14, 32'h00080000);
      `CHK(irq, 1'b0)
      `CHK(n_evt, 3)
      wr(8'h14, 32'h00080000);
      // Line 18 has no edge logic even with its enable written
      wr(8'h08, 32'h00040002);
      rd(8'h08, 32'h00000002);
      line <= 20'h40002;
      repeat (5) @(posedge ref_clk_i);
      rd(8'h14, 32'h00000002);
      `CHK(n_evt, 4)
      wr(8'h0C, 32'h00000002);
      rd(8'h14, 32'h00000000);
      wr(8'h20, 32'hFFFFFFFF);
      rd(8'h20, 32'h00000000);
      conclude();
   end

endmodule

`default_nettype wire
